/* File: dar_chk.sv */
// assertions on the responder's command and response ports
`timescale 1ns/1ps
module dar_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmd_valid,
   input wire logic [dar_pkg::CW_W-1:0] cmd_word,
   input wire logic cmd_long,
   input wire logic [dar_pkg::LEN_W-1:0] cmd_len,
   input wire logic [dar_pkg::AD_W-1:0] accel_result,
   input wire logic fault_flag,
   input wire logic rsp_valid,
   input wire logic [dar_pkg::RSP_W-1:0] rsp_data,
   input wire logic [dar_pkg::LEN_W-1:0] rsp_len
);
   // ********
   // helpers
   // ********
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic [3:0] code;
   wire logic [3:0] adr;
   assign code = cmd_word[3:0];
   assign adr = cmd_word[7:4];
   // ********
   // checks
   // ********
   rsp_cause_a: assert property (rsp_valid |->
      $past(cmd_valid, 2) && $past(code, 2) == dar_pkg::CMD_ACCEL)
      else $error("response without read command");
   unimpl_quiet_a: assert property (cmd_valid && code == dar_pkg::CMD_UNIMPL |->
      ##2 !rsp_valid)
      else $error("response to unimplemented code");
   global_quiet_a: assert property (cmd_valid && adr == dar_pkg::ADDR_GLOBAL |->
      ##2 !rsp_valid)
      else $error("response to global address");
   len_echo_a: assert property (rsp_valid |-> rsp_len == $past(cmd_len, 2))
      else $error("response length differs");
   long_head_a: assert property (rsp_valid && $past(cmd_long, 2) |->
      rsp_data[15:11] == {$past(adr, 2), 1'b0})
      else $error("long response head wrong");
   long_body_a: assert property (rsp_valid && $past(cmd_long, 2) |->
      rsp_data[10:0] == {$past(fault_flag, 2), $past(accel_result, 2)})
      else $error("long response body wrong");
   short_eight_a: assert property (rsp_valid && !$past(cmd_long, 2) && rsp_len == 5'h08 &&
      $past(accel_result, 2) > 10'h003 |->
      rsp_data == 16'($past(accel_result, 2) >> 2))
      else $error("eight bit response wrong");
   trunc_floor_a: assert property (rsp_valid && !$past(cmd_long, 2) && rsp_len < 5'h0A &&
      $past(accel_result, 2) != 10'h000 |-> rsp_data != 16'h0000)
      else $error("truncated zero sent");
   sensor_err_a: assert property (rsp_valid && !$past(cmd_long, 2) &&
      $past(accel_result, 2) == 10'h000 |-> rsp_data[9:0] == 10'h000)
      else $error("sensor error code lost");
   cover property (rsp_valid && rsp_len == 5'h08);
   cover property (rsp_valid && rsp_len == 5'h0F);
   cover property (cmd_valid && code == dar_pkg::CMD_UNIMPL);
endmodule
bind dar_top dar_chk u_chk (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
   .cmd_word(cmd_word), .cmd_long(cmd_long), .cmd_len(cmd_len),
   .accel_result(accel_result), .fault_flag(fault_flag), .rsp_valid(rsp_valid),
   .rsp_data(rsp_data), .rsp_len(rsp_len));

/* File: dar_evt_if.sv */
// event, mask and interrupt signals between core and status logic
`timescale 1ns/1ps
interface dar_evt_if;
   logic [dar_pkg::EV_W-1:0] ev;
   logic [dar_pkg::EV_W-1:0] ien;
   logic [dar_pkg::EV_W-1:0] clr;
   logic [dar_pkg::EV_W-1:0] stat;
   logic irq;
   modport core (output ev, output ien, output clr, input stat, input irq);
   modport stat_side (input ev, input ien, input clr, output stat, output irq);
endinterface

/* File: dar_fmt.sv */
// acceleration response formatter, long and short layouts
`timescale 1ns/1ps
module dar_fmt (
   input wire logic [dar_pkg::AD_W-1:0] ad,
   input wire logic err,
   input wire logic selftest_active_flag,
   input wire logic [1:0] attribute_bits,
   input wire logic [3:0] addr,
   input wire logic is_long,
   input wire logic [dar_pkg::LEN_W-1:0] len,
   output logic [dar_pkg::RSP_W-1:0] data,
   output logic floor_hit
);
   function automatic logic [dar_pkg::AD_W-1:0] dar_trunc(
      input logic [dar_pkg::AD_W-1:0] v,
      input logic [dar_pkg::LEN_W-1:0] n
   );
      return v >> (dar_pkg::LEN_AD - n);
   endfunction

   logic [dar_pkg::AD_W-1:0] cut;
   logic [dar_pkg::RSP_W-1:0] full;

   always_comb begin
      cut = dar_trunc(ad, len);
      floor_hit = 1'b0;
      full = {1'b0, attribute_bits[1], attribute_bits[0], selftest_active_flag,
         1'b0, err, ad};
      if (is_long) begin
         data = {addr, 1'b0, err, ad};
      end else if (len < dar_pkg::LEN_AD) begin
         // zero stays the sensor error code; a live value never truncates to it
         if (cut == dar_pkg::AD_ERR && ad != dar_pkg::AD_ERR) begin
            cut = dar_pkg::AD_MIN;
            floor_hit = 1'b1;
         end
         data = dar_pkg::RSP_W'(cut);
      end else begin
         data = full & ~(16'hFFFF << len);
      end
   end
endmodule

/* File: dar_irq.sv */
// sticky event status and level interrupt
`timescale 1ns/1ps
module dar_irq (
   input wire logic pclk,
   input wire logic presetn,
   dar_evt_if.stat_side evt
);
   logic [dar_pkg::EV_W-1:0] stat_nxt;

   // set wins over clear
   always_comb begin
      stat_nxt = (evt.stat & ~evt.clr) | evt.ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt.stat <= '0;
      end else begin
         evt.stat <= stat_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt.irq <= 1'b0;
      end else begin
         evt.irq <= |(stat_nxt & evt.ien);
      end
   end
endmodule

/* File: dar_master.sv */
// bus master model sending decoded request frames
`timescale 1ns/1ps
module dar_master (
   input wire logic pclk,
   output logic cmd_valid,
   output logic [dar_pkg::CW_W-1:0] cmd_word,
   output logic cmd_long,
   output logic cmd_enh,
   output logic [dar_pkg::LEN_W-1:0] cmd_len
);
   initial begin
      cmd_valid = 1'b0;
      cmd_word = 16'h0000;
      cmd_long = 1'b0;
      cmd_enh = 1'b0;
      cmd_len = 5'h00;
   end
   // ********
   // one frame, then a gap of idle cycles
   // ********
   task automatic send(input logic [15:0] w, input logic lg, input logic en,
      input logic [4:0] n, input int gap);
      @(posedge pclk);
      cmd_valid <= 1'b1;
      cmd_word <= w;
      cmd_long <= lg;
      cmd_enh <= en;
      cmd_len <= n;
      @(posedge pclk);
      cmd_valid <= 1'b0;
      cmd_word <= ~w;
      cmd_len <= ~n;
      repeat (gap) @(posedge pclk);
   endtask
endmodule

/* File: dar_pkg.sv */
// constants and types shared by the acceleration read responder
package dar_pkg;
   // ****************************************
   // command word and codes
   // ****************************************
   localparam int CW_W = 16;
   localparam int CW_C_LSB = 0;
   localparam int CW_A_LSB = 4;
   localparam int CW_D_LSB = 8;
   localparam logic [3:0] CMD_ACCEL = 4'h2;
   localparam logic [3:0] CMD_UNIMPL = 4'h3;
   localparam logic [3:0] ADDR_GLOBAL = 4'h0;
   // ****************************************
   // response layout
   // ****************************************
   localparam int AD_W = 10;
   localparam int RSP_W = 16;
   localparam int LEN_W = 5;
   localparam logic [LEN_W-1:0] LEN_AD = 5'h0A;
   localparam logic [AD_W-1:0] AD_MIN = 10'h001;
   localparam logic [AD_W-1:0] AD_ERR = 10'h000;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_ADDR = 8'h00;
   localparam logic [7:0] OFS_CFG1 = 8'h04;
   localparam logic [7:0] OFS_FMT = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_IEN = 8'h10;
   localparam logic [7:0] OFS_ICLR = 8'h14;
   localparam logic [7:0] OFS_LAST = 8'h18;
   localparam logic [7:0] OFS_CNT = 8'h1C;
   localparam logic [3:0] RST_ADDR = 4'h0;
   localparam logic [1:0] RST_ATTR = 2'h0;
   localparam logic [1:0] RST_FMT = 2'h0;
   localparam int FMT_ENH_LONG = 0;
   localparam int FMT_ENH_SHORT = 1;
   localparam int CNT_W = 16;
   // ****************************************
   // events and states
   // ****************************************
   localparam int EV_W = 4;
   localparam int EV_RSP = 0;
   localparam int EV_IGN = 1;
   localparam int EV_UNIMPL = 2;
   localparam int EV_DROP = 3;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DEC = 2'h1,
      ST_SEND = 2'h3
   } dar_state_t;
endpackage

/* File: dar_top.sv */
// acceleration read command responder with apb registers
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dar_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmd_valid,
   input wire logic [dar_pkg::CW_W-1:0] cmd_word,
   input wire logic cmd_long,
   input wire logic cmd_enh,
   input wire logic [dar_pkg::LEN_W-1:0] cmd_len,
   input wire logic [dar_pkg::AD_W-1:0] accel_result,
   input wire logic fault_flag,
   input wire logic selftest_active_flag,
   output logic rsp_valid,
   output logic [dar_pkg::RSP_W-1:0] rsp_data,
   output logic [dar_pkg::LEN_W-1:0] rsp_len,
   output logic irq
);
   // ****************************************
   // declarations
   // ****************************************
   dar_pkg::dar_state_t state_r;
   dar_pkg::dar_state_t state_nxt;
   logic [3:0] dev_addr_r;
   logic [1:0] attribute_bits_r;
   logic [1:0] fmt_ctrl_r;
   logic [dar_pkg::EV_W-1:0] ien_r;
   logic [3:0] cmd_code_r;
   logic [3:0] cmd_addr_r;
   logic cmd_long_r;
   logic cmd_enh_r;
   logic [dar_pkg::LEN_W-1:0] cmd_len_r;
   logic [dar_pkg::AD_W-1:0] ad_r;
   logic err_r;
   logic st_r;
   logic rsp_valid_r;
   logic [dar_pkg::RSP_W-1:0] rsp_data_r;
   logic [dar_pkg::LEN_W-1:0] rsp_len_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [dar_pkg::CNT_W-1:0] rsp_cnt_r;
   logic [dar_pkg::CNT_W-1:0] ign_cnt_r;
   logic setup;
   logic wr_acc;
   logic fmt_ok;
   logic is_accel;
   logic respond;
   logic addr_set;
   logic addr_match;
   logic is_unimpl;
   logic busy_drop;
   logic fire;
   logic rsp_floor_r;
   logic [dar_pkg::RSP_W-1:0] fmt_data;
   logic fmt_floor;
   logic [31:0] rd_nxt;
   dar_evt_if evt ();

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic dar_mapped(input logic [7:0] a);
      return a == dar_pkg::OFS_ADDR || a == dar_pkg::OFS_CFG1 ||
         a == dar_pkg::OFS_FMT || a == dar_pkg::OFS_STAT ||
         a == dar_pkg::OFS_IEN || a == dar_pkg::OFS_ICLR ||
         a == dar_pkg::OFS_LAST || a == dar_pkg::OFS_CNT;
   endfunction

   function automatic logic dar_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ****************************************
   // apb slave
   // ****************************************
   // pready answers in the first access cycle, no wait states
   assign setup = psel && !penable && !pready_r;
   assign wr_acc = psel && penable && pready_r && pwrite;

   always_comb begin
      rd_nxt = '0;
      unique case (paddr)
         dar_pkg::OFS_ADDR: begin
            rd_nxt = 32'(dev_addr_r);
         end
         dar_pkg::OFS_CFG1: begin
            rd_nxt = 32'(attribute_bits_r);
         end
         dar_pkg::OFS_FMT: begin
            rd_nxt = 32'(fmt_ctrl_r);
         end
         dar_pkg::OFS_STAT: begin
            rd_nxt = 32'(evt.stat);
         end
         dar_pkg::OFS_IEN: begin
            rd_nxt = 32'(ien_r);
         end
         dar_pkg::OFS_LAST: begin
            rd_nxt = 32'({rsp_floor_r, rsp_len_r, rsp_data_r});
         end
         dar_pkg::OFS_CNT: begin
            rd_nxt = {ign_cnt_r, rsp_cnt_r};
         end
         default: begin
            rd_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= setup;
         if (setup) begin
            pslverr_r <= !dar_mapped(paddr);
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_addr_r <= dar_pkg::RST_ADDR;
         attribute_bits_r <= dar_pkg::RST_ATTR;
         fmt_ctrl_r <= dar_pkg::RST_FMT;
         ien_r <= '0;
      end else if (wr_acc) begin
         if (dar_hit(paddr, dar_pkg::OFS_ADDR)) begin
            dev_addr_r <= pwdata[3:0];
         end
         if (dar_hit(paddr, dar_pkg::OFS_CFG1)) begin
            attribute_bits_r <= pwdata[1:0];
         end
         if (dar_hit(paddr, dar_pkg::OFS_FMT)) begin
            fmt_ctrl_r <= pwdata[1:0];
         end
         if (dar_hit(paddr, dar_pkg::OFS_IEN)) begin
            ien_r <= pwdata[dar_pkg::EV_W-1:0];
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ****************************************
   // command capture
   // ****************************************
   // data bits of the command word are never kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_code_r <= '0;
         cmd_addr_r <= '0;
         cmd_long_r <= 1'b0;
         cmd_enh_r <= 1'b0;
         cmd_len_r <= '0;
         ad_r <= '0;
         err_r <= 1'b0;
         st_r <= 1'b0;
      end else if (state_r == dar_pkg::ST_IDLE && cmd_valid) begin
         cmd_code_r <= cmd_word[dar_pkg::CW_C_LSB +: 4];
         cmd_addr_r <= cmd_word[dar_pkg::CW_A_LSB +: 4];
         cmd_long_r <= cmd_long;
         cmd_enh_r <= cmd_enh;
         cmd_len_r <= cmd_len;
         ad_r <= accel_result;
         err_r <= fault_flag;
         st_r <= selftest_active_flag;
      end
   end

   // ****************************************
   // decode
   // ****************************************
   assign is_accel = cmd_code_r == dar_pkg::CMD_ACCEL;
   assign fmt_ok = !cmd_enh_r ||
      (cmd_long_r ? fmt_ctrl_r[dar_pkg::FMT_ENH_LONG]
                  : fmt_ctrl_r[dar_pkg::FMT_ENH_SHORT]);
   // an unprogrammed device keeps the global address and stays quiet
   assign addr_set = dev_addr_r != dar_pkg::ADDR_GLOBAL;
   assign addr_match = cmd_addr_r == dev_addr_r;
   assign respond = is_accel && fmt_ok && addr_set && addr_match;
   assign is_unimpl = cmd_code_r == dar_pkg::CMD_UNIMPL;
   assign fire = state_r == dar_pkg::ST_DEC && respond;
   assign busy_drop = state_r != dar_pkg::ST_IDLE && cmd_valid;

   dar_fmt u_fmt (
      .ad(ad_r),
      .err(err_r),
      .selftest_active_flag(st_r),
      .attribute_bits(attribute_bits_r),
      .addr(dev_addr_r),
      .is_long(cmd_long_r),
      .len(cmd_len_r),
      .data(fmt_data),
      .floor_hit(fmt_floor)
   );

   // ****************************************
   // sequencer
   // ****************************************
   // a command seen outside idle is dropped and flagged
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         dar_pkg::ST_IDLE: begin
            if (cmd_valid) begin
               state_nxt = dar_pkg::ST_DEC;
            end
         end
         dar_pkg::ST_DEC: begin
            state_nxt = respond ? dar_pkg::ST_SEND : dar_pkg::ST_IDLE;
         end
         dar_pkg::ST_SEND: begin
            state_nxt = dar_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = dar_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= dar_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // response output
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid_r <= 1'b0;
      end else begin
         rsp_valid_r <= fire;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_data_r <= '0;
         rsp_len_r <= '0;
         rsp_floor_r <= 1'b0;
      end else if (fire) begin
         rsp_data_r <= fmt_data;
         rsp_len_r <= cmd_len_r;
         rsp_floor_r <= fmt_floor;
      end
   end

   assign rsp_valid = rsp_valid_r;
   assign rsp_data = rsp_data_r;
   assign rsp_len = rsp_len_r;

   // ****************************************
   // counters
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_cnt_r <= '0;
      end else if (state_r == dar_pkg::ST_DEC && respond) begin
         rsp_cnt_r <= rsp_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ign_cnt_r <= '0;
      end else if (state_r == dar_pkg::ST_DEC && !respond && is_accel) begin
         ign_cnt_r <= ign_cnt_r + 16'h0001;
      end
   end

   // ****************************************
   // events and interrupt
   // ****************************************
   always_comb begin
      evt.ev = '0;
      evt.ev[dar_pkg::EV_RSP] = state_r == dar_pkg::ST_DEC && respond;
      evt.ev[dar_pkg::EV_IGN] = state_r == dar_pkg::ST_DEC && is_accel && !respond;
      evt.ev[dar_pkg::EV_UNIMPL] = state_r == dar_pkg::ST_DEC && is_unimpl;
      evt.ev[dar_pkg::EV_DROP] = busy_drop;
   end

   // ****************************************
   // interrupt
   // ****************************************
   always_comb begin
      evt.ien = ien_r;
      evt.clr = '0;
      if (wr_acc && dar_hit(paddr, dar_pkg::OFS_ICLR)) begin
         evt.clr = pwdata[dar_pkg::EV_W-1:0];
      end
   end

   dar_irq u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .evt(evt)
   );

   assign irq = evt.irq;
endmodule

/* File: dsi_accel_read_responder_tb.sv */
// self-checking bench for the acceleration read responder
`timescale 1ns/1ps
module dsi_accel_read_responder_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rsp_valid, irq, cmd_valid, cmd_long, cmd_enh;
   logic [15:0] cmd_word, rsp_data;
   logic [4:0] cmd_len, rsp_len;
   logic [9:0] ad = 10'h000;
   logic flt = 1'b0;
   logic stf = 1'b0;
   logic [31:0] seed = 32'h0000000A;
   logic [31:0] q, rv;
   int n_mismatch = 0;
   int total_checks = 0;
   int dev = 0;
   int at = 0;
   int fmt = 0;
   int n_rsp = 0;
   int n_ign = 0;
   logic [15:0] expq[$];
   logic [4:0] lenq[$];
   logic [3:0] codes[4] = '{4'h2, 4'h2, 4'h3, 4'h2};
   logic [3:0] adrs[3] = '{4'h5, 4'h5, 4'h9};
   logic [9:0] ads[6] = '{10'h000, 10'h001, 10'h003, 10'h004, 10'h3FF, 10'h202};
   always #25 pclk = ~pclk;
   dar_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_long(cmd_long),
      .cmd_enh(cmd_enh), .cmd_len(cmd_len), .accel_result(ad), .fault_flag(flt),
      .selftest_active_flag(stf), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_len(rsp_len), .irq(irq));
   dar_master u_m (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .cmd_long(cmd_long), .cmd_enh(cmd_enh), .cmd_len(cmd_len));
   // ********
   // helpers
   // ********
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk_rsp(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: response %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: register %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_reg(q, e);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic lg,
      input logic en, input logic [4:0] n, input logic [9:0] v);
      logic [31:0] r;
      logic [15:0] e;
      r = rnd();
      if (lg) n = 5'h00;
      ad <= v;
      flt <= r[0];
      stf <= r[1];
      if (c == 4'h2 && a != 4'h0 && a == dev[3:0] && (!en || (lg ? fmt[0] : fmt[1]))) begin
         if (lg) e = {a, 1'b0, r[0], v};
         else if (n < 10) begin
            e = 16'(v >> (10 - n));
            if (e == 16'h0000 && v != 10'h000) e = 16'h0001;
         end else e = 16'({at[1:0], r[1], 1'b0, r[0], v}) & 16'((1 << n) - 1);
         expq.push_back(e);
         lenq.push_back(n);
         n_rsp++;
      end else if (c == 4'h2) n_ign++;
      u_m.send({r[15:8], a, c}, lg, en, n, 1 + int'(r[3:2]));
   endtask
   always @(posedge pclk) begin
      if (rsp_valid === 1'b1) begin
         if (expq.size() == 0) begin
            chk_rsp(rsp_data, ~rsp_data);
         end else begin
            chk_rsp(rsp_data, expq.pop_front());
            chk_rsp({11'h0, rsp_len}, {11'h0, lenq.pop_front()});
         end
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ********
   // sequence
   // ********
   initial begin
      #2000000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(dar_pkg::OFS_ADDR, 32'h0);
      rd(dar_pkg::OFS_CFG1, 32'h0);
      rd(8'h40, 32'h0);
      chk_reg({31'h0, pslverr}, 32'h1);
      cmd(4'h2, 4'h0, 1'b1, 1'b0, 5'h00, 10'h202);
      dev = 5;
      apb(1'b1, dar_pkg::OFS_ADDR, 32'h5);
      for (int p = 0; p < 2; p++) begin
         fmt = 3 * p;
         at = p + 1;
         apb(1'b1, dar_pkg::OFS_FMT, fmt);
         apb(1'b1, dar_pkg::OFS_CFG1, at);
         rd(dar_pkg::OFS_CFG1, at);
         for (int i = 0; i < 48; i++) begin
            rv = rnd();
            cmd(codes[i % 4], adrs[i % 3], rv[4], rv[5], 5'(8 + i % 8),
               (i % 7 < 6) ? ads[i % 7] : rv[25:16]);
         end
      end
      repeat (6) @(posedge pclk);
      chk_reg(expq.size(), 32'h0);
      rd(dar_pkg::OFS_CNT, {n_ign[15:0], n_rsp[15:0]});
      apb(1'b1, dar_pkg::OFS_ICLR, 32'hF);
      apb(1'b1, dar_pkg::OFS_IEN, 32'h4);
      rd(dar_pkg::OFS_STAT, 32'h0);
      cmd(4'h3, 4'h5, 1'b1, 1'b0, 5'h00, 10'h100);
      rd(dar_pkg::OFS_STAT, 32'h4);
      chk_reg({31'h0, irq}, 32'h1);
      apb(1'b1, dar_pkg::OFS_ICLR, 32'h4);
      repeat (2) @(posedge pclk);
      chk_reg({31'h0, irq}, 32'h0);
      cmd(4'h2, 4'h9, 1'b0, 1'b0, 5'h08, 10'h202);
      rd(dar_pkg::OFS_STAT, 32'h2);
      chk_reg({31'h0, irq}, 32'h0);
      apb(1'b1, dar_pkg::OFS_ICLR, 32'hF);
      ad <= 10'h202;
      flt <= 1'b0;
      expq.push_back(16'h5202);
      lenq.push_back(5'h00);
      u_m.send(16'h0052, 1'b1, 1'b0, 5'h00, 0);
      u_m.send(16'h0052, 1'b1, 1'b0, 5'h00, 4);
      rd(dar_pkg::OFS_STAT, 32'h9);
      rd(dar_pkg::OFS_LAST, 32'h0000_5202);
      chk_reg(expq.size(), 32'h0);
      stop_test();
   end
endmodule
